/* hw/pa_pkg.sv */
package pa_pkg;
  localparam int PA_W = 6;
  localparam int PA_AW = 4;
  localparam int PA_DW = 8;
  // Register indices on the plain register port.
  localparam logic [PA_AW-1:0] PA_ADDR_LEVEL = 4'h0;
  localparam logic [PA_AW-1:0] PA_ADDR_LATCH = 4'h1;
  localparam logic [PA_AW-1:0] PA_ADDR_DIR = 4'h2;
  localparam logic [PA_AW-1:0] PA_ADDR_ANSEL = 4'h3;
  localparam logic [PA_AW-1:0] PA_ADDR_PULLUP = 4'h4;
  localparam logic [PA_AW-1:0] PA_ADDR_THRESH = 4'h5;
  localparam logic [PA_AW-1:0] PA_ADDR_OPTION = 4'h6;
  localparam logic [PA_AW-1:0] PA_ADDR_STEER0 = 4'h7;
  localparam logic [PA_AW-1:0] PA_ADDR_STEER1 = 4'h8;
  // Implemented bits and reset values.
  localparam logic [PA_W-1:0] PA_LATCH_MASK = 6'h37;
  localparam logic [PA_W-1:0] PA_ANSEL_MASK = 6'h17;
  localparam logic [PA_W-1:0] PA_INPUT_ONLY = 6'h08;
  localparam logic [PA_W-1:0] PA_DIR_RESET = 6'h3f;
  localparam logic [PA_W-1:0] PA_ANSEL_RESET = 6'h17;
  localparam logic [PA_W-1:0] PA_PULLUP_RESET = 6'h3f;
  localparam logic [PA_W-1:0] PA_THRESH_RESET = 6'h04;
  localparam logic [PA_W-1:0] PA_LATCH_RESET = 6'h00;
  localparam logic [PA_DW-1:0] PA_STEER0_MASK_14 = 8'hec;
  localparam logic [PA_DW-1:0] PA_STEER0_MASK_20 = 8'h8c;
  localparam logic [PA_DW-1:0] PA_STEER1_MASK = 8'h0f;
  localparam logic [PA_DW-1:0] PA_STEER_RESET = 8'h00;
  localparam logic PA_GPD_RESET = 1'b1;
  // Field positions.
  localparam int PA_OPT_GPD = 7;
  localparam int PA_S0_RX = 7;
  localparam int PA_S0_SDO = 6;
  localparam int PA_S0_SS = 5;
  localparam int PA_S0_T1G = 3;
  localparam int PA_S0_TX = 2;
  localparam int PA_S1_P1D = 3;
  localparam int PA_S1_P1C = 2;
  localparam int PA_S1_P2B = 1;
  localparam int PA_S1_CAPTURE_UNIT2_PIN = 0;

  // One peripheral output: enable and level.
  typedef struct packed {
    logic en;
    logic val;
  } pa_fn_t;

  // Peripheral outputs that may claim a port A pin.
  typedef struct packed {
    pa_fn_t prog_data_pin;
    pa_fn_t debug_data_pin;
    pa_fn_t dac_voltage_out;
    pa_fn_t serial_transmit_clock;
    pa_fn_t prog_clock_pin;
    pa_fn_t debug_clock_pin;
    pa_fn_t serial_receive_data;
    pa_fn_t sr_latch_out;
    pa_fn_t comparator1_out;
    pa_fn_t capture_unit3_pin;
    pa_fn_t system_clock_out;
    pa_fn_t timer1_osc_out;
    pa_fn_t reference_clock_out;
    pa_fn_t serial_data_out;
    pa_fn_t pwm_out_2b;
    pa_fn_t capture_unit2_pin;
  } pa_periph_t;

  // Digital levels of other port pins that a steered input may come from.
  typedef struct packed {
    logic port_b_pin5;
    logic port_c_pin3;
    logic port_c_pin5;
  } pa_other_t;

  // Steered peripheral inputs.
  typedef struct packed {
    logic serial_receive_data;
    logic slave_select;
    logic timer1_gate_input;
  } pa_steered_t;
endpackage : pa_pkg

/* hw/pa_port.sv */
// Functional notes
// - Writing the latch register updates the latch like a pin-level write.
// - Latch read returns latch; pin-level read returns pin levels.
// - Direction bit one makes the pin an input, driver off.
// - Direction bit zero enables the driver with the latch value.
// - Pin 3 is input only; its direction bit reads one.
// - Six-bit port with one direction, latch and level bit per pin.
// - Pin-level write stores the written value, masked, straight into the output latch.
// - Direction bits control drivers even on analog pins.
// - Analog-selected pins read zero digitally.
// - Threshold bit picks Schmitt or TTL for reads.
// - Each pin has its own pull-up enable bit.
// - Pull-up is forced off while the pin is an output.
// - Power-on reset disables all pull-ups via the global disable bit.
// - Analog select does not affect digital output drive.
// - Steering bits leave direction bits alone; overrides follow the function.
// - Steering 0 bit 7 routes serial receive per pin-count variant.
// - Steering 0 bit 6 routes serial data out; zero on 20-pin.
// - Steering 0 bit 5 routes slave select; zero on 20-pin.
// - Steering 0 bit 3 routes timer 1 gate to pin 4 or 3.
// - Steering 0 bit 2 routes serial transmit to pin 0 on 14-pin; stored but unused on 20-pin.
// - Steering 1 bits 1..0 route PWM 2B to pin 4 and capture 2 to pin 5; bits 3..2 are stored only; upper bits zero.
// - Lowest-numbered enabled output owns the pin.
// - Individual pull-ups act only while the global disable is clear.
//
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module pa_port #(
  parameter bit IS_14_PIN = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [pa_pkg::PA_AW-1:0] reg_addr,
  input wire logic [pa_pkg::PA_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [pa_pkg::PA_DW-1:0] reg_rdata,
  input wire logic [pa_pkg::PA_W-1:0] pin_in,
  output logic [pa_pkg::PA_W-1:0] pin_out,
  output logic [pa_pkg::PA_W-1:0] pin_oe,
  output logic [pa_pkg::PA_W-1:0] pullup_on,
  output logic [pa_pkg::PA_W-1:0] schmitt_sel,
  output logic [pa_pkg::PA_W-1:0] pin_digital,
  input wire pa_pkg::pa_periph_t periph,
  input wire pa_pkg::pa_other_t other_pins,
  output pa_pkg::pa_steered_t steered,
  output logic [pa_pkg::PA_DW-1:0] alt_function_steering_0,
  output logic [pa_pkg::PA_DW-1:0] alt_function_steering_1
);
  import pa_pkg::*;

  localparam logic [PA_DW-1:0] STEER0_MASK = IS_14_PIN ? PA_STEER0_MASK_14 : PA_STEER0_MASK_20;

  typedef struct packed {
    logic [PA_W-1:0] output_latch_register;
    logic [PA_W-1:0] pin_direction_bits;
    logic [PA_W-1:0] analog_select_bits;
    logic [PA_W-1:0] pullup_enable_bits;
    logic [PA_W-1:0] input_threshold_select;
    logic global_pullup_disable;
    logic [PA_DW-1:0] steer0;
    logic [PA_DW-1:0] steer1;
    logic [PA_W-1:0] sync1;
    logic [PA_W-1:0] sync2;
    logic [PA_W-1:0] dig;
    logic [PA_W-1:0] out;
    logic [PA_W-1:0] oe;
    logic [PA_W-1:0] pull;
    logic [PA_DW-1:0] rdata;
    pa_steered_t st;
  } pa_state_t;

  pa_state_t state;
  pa_state_t next_state;
  logic [PA_W-1:0] level;
  logic [PA_W-1:0] drive;
  logic [PA_DW-1:0] read_mux;

  // Digital view of the pins; analog-selected pins read zero.
  // analog reads zero
  assign level = state.sync2 & ~state.analog_select_bits;

  // Output priority chains; the latch drives when no function claims the pin.
  always_comb begin
    drive = state.output_latch_register;
    if (periph.prog_data_pin.en) begin
      drive[0] = periph.prog_data_pin.val;
    end else if (periph.debug_data_pin.en) begin
      drive[0] = periph.debug_data_pin.val;
    end else if (periph.dac_voltage_out.en) begin
      drive[0] = periph.dac_voltage_out.val;
    end else if (IS_14_PIN && state.steer0[PA_S0_TX] && periph.serial_transmit_clock.en) begin
      drive[0] = periph.serial_transmit_clock.val;
    end
    if (periph.prog_clock_pin.en) begin
      drive[1] = periph.prog_clock_pin.val;
    end else if (periph.debug_clock_pin.en) begin
      drive[1] = periph.debug_clock_pin.val;
    end else if (IS_14_PIN && state.steer0[PA_S0_RX] && periph.serial_receive_data.en) begin
      drive[1] = periph.serial_receive_data.val;
    end
    if (periph.sr_latch_out.en) begin
      drive[2] = periph.sr_latch_out.val;
    end else if (periph.comparator1_out.en) begin
      drive[2] = periph.comparator1_out.val;
    end else if (periph.capture_unit3_pin.en) begin
      drive[2] = periph.capture_unit3_pin.val;
    end
    drive[3] = 1'b0;
    if (periph.system_clock_out.en) begin
      drive[4] = periph.system_clock_out.val;
    end else if (periph.timer1_osc_out.en) begin
      drive[4] = periph.timer1_osc_out.val;
    end else if (periph.reference_clock_out.en) begin
      drive[4] = periph.reference_clock_out.val;
    end else if (IS_14_PIN && state.steer0[PA_S0_SDO] && periph.serial_data_out.en) begin
      drive[4] = periph.serial_data_out.val;
    end else if (state.steer1[PA_S1_P2B] && periph.pwm_out_2b.en) begin
      drive[4] = periph.pwm_out_2b.val;
    end
    if (state.steer1[PA_S1_CAPTURE_UNIT2_PIN] && periph.capture_unit2_pin.en) begin
      drive[5] = periph.capture_unit2_pin.val;
    end
  end

  always_comb begin
    case (reg_addr)
      PA_ADDR_LEVEL: read_mux = {2'h0, level};
      PA_ADDR_LATCH: read_mux = {2'h0, state.output_latch_register & PA_LATCH_MASK};
      PA_ADDR_DIR: read_mux = {2'h0, state.pin_direction_bits | PA_INPUT_ONLY};
      PA_ADDR_ANSEL: read_mux = {2'h0, state.analog_select_bits};
      PA_ADDR_PULLUP: read_mux = {2'h0, state.pullup_enable_bits};
      PA_ADDR_THRESH: read_mux = {2'h0, state.input_threshold_select};
      PA_ADDR_OPTION: read_mux = {state.global_pullup_disable, 7'h00};
      PA_ADDR_STEER0: read_mux = state.steer0;
      PA_ADDR_STEER1: read_mux = state.steer1;
      default: read_mux = 8'h00;
    endcase
  end

  always_comb begin
    next_state = state;
    next_state.sync1 = pin_in;
    next_state.sync2 = state.sync1;
    next_state.dig = level;
    next_state.rdata = reg_rd ? read_mux : 8'h00;
    if (reg_wr) begin
      case (reg_addr)
        PA_ADDR_LEVEL: next_state.output_latch_register = reg_wdata[PA_W-1:0] & PA_LATCH_MASK;
        PA_ADDR_LATCH: next_state.output_latch_register = reg_wdata[PA_W-1:0] & PA_LATCH_MASK;
        PA_ADDR_DIR: next_state.pin_direction_bits = reg_wdata[PA_W-1:0] | PA_INPUT_ONLY;
        PA_ADDR_ANSEL: next_state.analog_select_bits = reg_wdata[PA_W-1:0] & PA_ANSEL_MASK;
        PA_ADDR_PULLUP: next_state.pullup_enable_bits = reg_wdata[PA_W-1:0];
        PA_ADDR_THRESH: next_state.input_threshold_select = reg_wdata[PA_W-1:0];
        PA_ADDR_OPTION: next_state.global_pullup_disable = reg_wdata[PA_OPT_GPD];
        PA_ADDR_STEER0: next_state.steer0 = reg_wdata & STEER0_MASK;
        PA_ADDR_STEER1: next_state.steer1 = reg_wdata & PA_STEER1_MASK;
        default: next_state.steer1 = state.steer1;
      endcase
    end
    next_state.oe = ~(state.pin_direction_bits | PA_INPUT_ONLY);
    next_state.out = drive;
    next_state.pull = state.global_pullup_disable ? '0
                    : (state.pullup_enable_bits & (state.pin_direction_bits | PA_INPUT_ONLY));
    // timer gate from pin 4 or 3
    next_state.st.timer1_gate_input = state.steer0[PA_S0_T1G] ? level[3] : level[4];
    if (IS_14_PIN) begin
      next_state.st.serial_receive_data =
        state.steer0[PA_S0_RX] ? level[1] : other_pins.port_c_pin5;
    end else begin
      next_state.st.serial_receive_data =
        state.steer0[PA_S0_RX] ? other_pins.port_c_pin5 : other_pins.port_b_pin5;
    end
    next_state.st.slave_select =
      (IS_14_PIN && state.steer0[PA_S0_SS]) ? level[3] : other_pins.port_c_pin3;
    if (rst) begin
      next_state = '0;
      next_state.output_latch_register = PA_LATCH_RESET;
      next_state.pin_direction_bits = PA_DIR_RESET;
      next_state.analog_select_bits = PA_ANSEL_RESET;
      next_state.pullup_enable_bits = PA_PULLUP_RESET;
      next_state.input_threshold_select = PA_THRESH_RESET;
      next_state.global_pullup_disable = PA_GPD_RESET;
      next_state.steer0 = PA_STEER_RESET;
      next_state.steer1 = PA_STEER_RESET;
    end
  end

  always_ff @(posedge clk) begin
    state <= next_state;
  end

  assign reg_rdata = state.rdata;
  assign pin_out = state.out;
  assign pin_oe = state.oe;
  assign pullup_on = state.pull;
  assign schmitt_sel = state.input_threshold_select;
  assign pin_digital = state.dig;
  assign steered = state.st;
  assign alt_function_steering_0 = state.steer0;
  assign alt_function_steering_1 = state.steer1;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_latch_write: assert property (
    (reg_wr && reg_addr == PA_ADDR_LATCH) |=> (state.output_latch_register
      == ($past(reg_wdata[PA_W-1:0]) & PA_LATCH_MASK)))
    else $error("latch write not stored");
  chk_level_write: assert property (
    (reg_wr && reg_addr == PA_ADDR_LEVEL) |=> (state.output_latch_register
      == ($past(reg_wdata[PA_W-1:0]) & PA_LATCH_MASK)))
    else $error("pin-level write not merged into latch");
  chk_level_read: assert property (
    (reg_rd && reg_addr == PA_ADDR_LEVEL) |=> (reg_rdata == {2'h0, $past(level)}))
    else $error("pin-level read wrong");

  chk_pin3_no_drive: assert property (
    !pin_oe[3] && !pin_out[3])
    else $error("pin 3 driven");

  chk_dir3_read: assert property (
    (reg_rd && reg_addr == PA_ADDR_DIR) |=> reg_rdata[3])
    else $error("pin 3 direction bit reads zero");

  chk_dir_drive: assert property (
    ##1 (pin_oe == ~($past(state.pin_direction_bits) | PA_INPUT_ONLY)))
    else $error("driver enable does not follow direction");

  chk_analog_zero: assert property (
    ##1 ((pin_digital & $past(state.analog_select_bits)) == '0))
    else $error("analog pin read nonzero");

  chk_pull_output: assert property (
    ##1 ((pullup_on & ~($past(state.pin_direction_bits))) == '0))
    else $error("pull-up on while output");

  chk_pull_global: assert property (
    $past(state.global_pullup_disable) |-> (pullup_on == '0))
    else $error("pull-up on while globally disabled");

  chk_steer1_upper: assert property (
    (reg_rd && reg_addr == PA_ADDR_STEER1) |=> (reg_rdata[7:4] == 4'h0))
    else $error("steering 1 upper bits nonzero");

  chk_gate_route: assert property (
    ##1 (steered.timer1_gate_input
      == ($past(state.steer0[PA_S0_T1G]) ? $past(level[3]) : $past(level[4]))))
    else $error("timer gate routed wrong");

  chk_prio_pin0: assert property (
    periph.prog_data_pin.en |=> (pin_out[0] == $past(periph.prog_data_pin.val)))
    else $error("pin 0 priority wrong");

  chk_latch_read: assert property (
    (reg_rd && reg_addr == PA_ADDR_LATCH) |=> (reg_rdata == {2'h0, $past(state.output_latch_register)}))
    else $error("latch read wrong");

  chk_rdata_idle: assert property (
    !reg_rd |=> (reg_rdata == 8'h00))
    else $error("read data not zero outside a read");

  chk_out_latch: assert property (
    (periph == '0) |=> (pin_out == $past(state.output_latch_register)))
    else $error("pin drive does not follow latch");

  chk_analog_drive: assert property (
    (periph == '0 && state.analog_select_bits != '0)
    |=> (pin_out == $past(state.output_latch_register)))
    else $error("analog select changed digital drive");

  chk_analog_dir: assert property (
    (state.analog_select_bits != '0)
    |=> (pin_oe == ~($past(state.pin_direction_bits) | PA_INPUT_ONLY)))
    else $error("direction ignored on analog pin");

  chk_steer0_mask: assert property (
    (reg_wr && reg_addr == PA_ADDR_STEER0)
    |=> (alt_function_steering_0 == ($past(reg_wdata) & STEER0_MASK)))
    else $error("steering 0 write wrong");

  chk_dir_steer: assert property (
    (reg_wr && (reg_addr == PA_ADDR_STEER0 || reg_addr == PA_ADDR_STEER1))
    |=> $stable(state.pin_direction_bits))
    else $error("steering write changed direction");

  chk_rx_route: assert property (
    ##1 (steered.serial_receive_data == ($past(state.steer0[PA_S0_RX])
      ? (IS_14_PIN ? $past(level[1]) : $past(other_pins.port_c_pin5))
      : (IS_14_PIN ? $past(other_pins.port_c_pin5) : $past(other_pins.port_b_pin5)))))
    else $error("receive input routed wrong");

  chk_ss_route: assert property (
    ##1 (steered.slave_select == (($past(state.steer0[PA_S0_SS]) && IS_14_PIN)
      ? $past(level[3]) : $past(other_pins.port_c_pin3))))
    else $error("slave select routed wrong");

  chk_tx_pin0: assert property (
    (IS_14_PIN && state.steer0[PA_S0_TX] && periph.serial_transmit_clock.en
      && !periph.prog_data_pin.en && !periph.debug_data_pin.en && !periph.dac_voltage_out.en)
    |=> (pin_out[0] == $past(periph.serial_transmit_clock.val)))
    else $error("transmit not on pin 0");

  chk_prio_pin1: assert property (
    periph.prog_clock_pin.en |=> (pin_out[1] == $past(periph.prog_clock_pin.val)))
    else $error("pin 1 priority wrong");

  chk_prio_pin2: assert property (
    periph.sr_latch_out.en |=> (pin_out[2] == $past(periph.sr_latch_out.val)))
    else $error("pin 2 priority wrong");

  chk_prio_pin4: assert property (
    periph.system_clock_out.en |=> (pin_out[4] == $past(periph.system_clock_out.val)))
    else $error("pin 4 priority wrong");

  chk_capture_unit2_pin_pin5: assert property (
    (state.steer1[PA_S1_CAPTURE_UNIT2_PIN] && periph.capture_unit2_pin.en)
    |=> (pin_out[5] == $past(periph.capture_unit2_pin.val)))
    else $error("capture 2 not on pin 5");

  chk_pwm_pin4: assert property (
    (state.steer1[PA_S1_P2B] && periph.pwm_out_2b.en && !periph.system_clock_out.en
      && !periph.timer1_osc_out.en && !periph.reference_clock_out.en
      && !(IS_14_PIN && state.steer0[PA_S0_SDO] && periph.serial_data_out.en))
    |=> (pin_out[4] == $past(periph.pwm_out_2b.val)))
    else $error("pwm 2b not on pin 4");

  chk_pull_enable: assert property (
    !state.global_pullup_disable
    |=> (pullup_on == ($past(state.pullup_enable_bits) & $past(state.pin_direction_bits))))
    else $error("pull-up does not follow its enable bit");

  chk_reset_gpd: assert property (
    $past(rst) |-> state.global_pullup_disable)
    else $error("global pull-up disable clear after reset");

  chk_thresh_out: assert property (
    (reg_wr && reg_addr == PA_ADDR_THRESH) |=> (schmitt_sel == $past(reg_wdata[PA_W-1:0])))
    else $error("threshold select not applied");

  cov_level_write: cover property (reg_wr && reg_addr == PA_ADDR_LEVEL ##1 pin_oe != '0);
  cov_pull_active: cover property (pullup_on != '0);
  cov_steer_pwm: cover property (state.steer1[PA_S1_P2B] && periph.pwm_out_2b.en);
  cov_tx_pin0: cover property (state.steer0[PA_S0_TX] && periph.serial_transmit_clock.en);
  cov_steer_rx: cover property (state.steer0[PA_S0_RX] && steered.serial_receive_data);
endmodule : pa_port
`default_nettype wire

/* test/pa_pins_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pa_pins_model (
  input wire logic clk,
  input wire logic [pa_pkg::PA_W-1:0] pin_out,
  input wire logic [pa_pkg::PA_W-1:0] pin_oe,
  input wire logic [pa_pkg::PA_W-1:0] pullup_on,
  input wire logic [pa_pkg::PA_W-1:0] ext_en,
  input wire logic [pa_pkg::PA_W-1:0] ext_val,
  output logic [pa_pkg::PA_W-1:0] pin_in
);
  import pa_pkg::*;
  logic [PA_W-1:0] last_level = '0;
  // A pad nobody drives or pulls toggles every cycle, so a stale value never reads as valid.
  always_comb begin
    for (int i = 0; i < PA_W; i++) begin
      if (pin_oe[i]) begin
        pin_in[i] = pin_out[i];
      end else if (ext_en[i]) begin
        pin_in[i] = ext_val[i];
      end else if (pullup_on[i]) begin
        pin_in[i] = 1'b1;
      end else begin
        pin_in[i] = ~last_level[i];
      end
    end
  end
  always @(posedge clk) begin
    last_level <= pin_in;
  end
endmodule : pa_pins_model
`default_nettype wire

/* test/pa_port_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module pa_port_bench;
  import pa_pkg::*;
  typedef struct packed {
    logic [PA_AW-1:0] a;
    logic [PA_DW-1:0] d;
    logic [PA_DW-1:0] e;
  } pa_row_t;
  localparam pa_row_t ROWS [10] = '{'{PA_ADDR_LATCH, 8'hff, 8'h37},
    '{PA_ADDR_LATCH, 8'h00, 8'h00}, '{PA_ADDR_DIR, 8'h00, 8'h08},
    '{PA_ADDR_ANSEL, 8'hff, 8'h17}, '{PA_ADDR_ANSEL, 8'h00, 8'h00},
    '{PA_ADDR_PULLUP, 8'h2a, 8'h2a}, '{PA_ADDR_THRESH, 8'hff, 8'h3f},
    '{PA_ADDR_STEER0, 8'hff, 8'hec}, '{PA_ADDR_STEER1, 8'hff, 8'h0f},
    '{4'hf, 8'hff, 8'h00}};
  localparam pa_row_t RST [7] = '{'{PA_ADDR_DIR, 8'h00, 8'h3f},
    '{PA_ADDR_ANSEL, 8'h00, 8'h17}, '{PA_ADDR_PULLUP, 8'h00, 8'h3f},
    '{PA_ADDR_THRESH, 8'h00, 8'h04}, '{PA_ADDR_LATCH, 8'h00, 8'h00},
    '{PA_ADDR_STEER0, 8'h00, 8'h00}, '{PA_ADDR_STEER1, 8'h00, 8'h00}};
  logic clk, rst, reg_wr, reg_rd;
  logic [PA_AW-1:0] reg_addr;
  logic [PA_DW-1:0] reg_wdata, reg_rdata, s0, s1, v;
  logic [PA_W-1:0] pin_in, pin_out, pin_oe, pullup_on, schmitt_sel, pin_digital, ext_en, ext_val;
  pa_periph_t periph;
  pa_other_t oth;
  pa_steered_t steered;
  int bad_count, check_count;

  pa_port dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pullup_on(pullup_on), .schmitt_sel(schmitt_sel),
    .pin_digital(pin_digital), .periph(periph), .other_pins(oth), .steered(steered),
    .alt_function_steering_0(s0), .alt_function_steering_1(s1));
  pa_pins_model pins (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_on(pullup_on),
    .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic report_and_stop;
    if (bad_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic wr(input logic [PA_AW-1:0] a, input logic [PA_DW-1:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rc(input string n, input logic [PA_AW-1:0] a, input logic [PA_DW-1:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(n, reg_rdata, e);
  endtask : rc

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_n

  task automatic out_is(input logic [7:0] e);
    wait_n(3);
    chk("pin_out", 8'(pin_out), e);
  endtask : out_is

  initial begin
    #(25 * 4000);
    bad_count++;
    report_and_stop;
  end

  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    periph = '0;
    oth = '0;
    ext_en = 6'h3f;
    ext_val = 6'h00;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    foreach (ROWS[i]) begin
      wr(ROWS[i].a, ROWS[i].d);
      rc("table", ROWS[i].a, ROWS[i].e);
    end
    chk("steer0 copy", s0, 8'hec);
    chk("steer1 copy", s1, 8'h0f);
    @(posedge clk);
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    foreach (RST[i]) rc("reset", RST[i].a, RST[i].e);
    rc("option", PA_ADDR_OPTION, 8'h80);
    chk("pullup_on", 8'(pullup_on), 8'h00);
    chk("pin_oe", 8'(pin_oe), 8'h00);
    chk("schmitt_sel", 8'(schmitt_sel), 8'h04);
    ext_en <= 6'h08;
    ext_val <= 6'h08;
    wr(PA_ADDR_DIR, 8'h00);
    wr(PA_ADDR_LATCH, 8'h35);
    wait_n(6);
    chk("pin_oe", 8'(pin_oe), 8'h37);
    chk("pin_out", 8'(pin_out), 8'h35);
    chk("pin_digital", 8'(pin_digital), 8'h28);
    rc("level", PA_ADDR_LEVEL, 8'h28);
    rc("latch", PA_ADDR_LATCH, 8'h35);
    wr(PA_ADDR_LEVEL, 8'h2a);
    rc("latch", PA_ADDR_LATCH, 8'h22);
    out_is(8'h22);
    ext_en <= 6'h3f;
    ext_val <= 6'h15;
    wr(PA_ADDR_ANSEL, 8'h00);
    wr(PA_ADDR_DIR, 8'h3f);
    wait_n(6);
    chk("pin_oe", 8'(pin_oe), 8'h00);
    rc("level", PA_ADDR_LEVEL, 8'h15);
    rc("latch", PA_ADDR_LATCH, 8'h22);
    wr(PA_ADDR_OPTION, 8'h00);
    wait_n(3);
    chk("pullup_on", 8'(pullup_on), 8'h3f);
    wr(PA_ADDR_PULLUP, 8'h2a);
    wait_n(3);
    chk("pullup_on", 8'(pullup_on), 8'h2a);
    wr(PA_ADDR_DIR, 8'h00);
    wait_n(3);
    chk("pullup_on", 8'(pullup_on), 8'h08);
    // Threshold changes while every peripheral output is still idle.
    wr(PA_ADDR_THRESH, 8'h2b);
    wait_n(3);
    chk("schmitt_sel", 8'(schmitt_sel), 8'h2b);
    wr(PA_ADDR_LATCH, 8'h00);
    wr(PA_ADDR_STEER0, 8'h04);
    periph.serial_transmit_clock <= 2'b11;
    out_is(8'h01);
    periph.dac_voltage_out <= 2'b10;
    out_is(8'h00);
    periph.debug_data_pin <= 2'b11;
    out_is(8'h01);
    periph.prog_data_pin <= 2'b10;
    periph.pwm_out_2b <= 2'b11;
    out_is(8'h00);
    wr(PA_ADDR_STEER1, 8'h02);
    out_is(8'h10);
    wr(PA_ADDR_STEER0, 8'h44);
    periph.serial_data_out <= 2'b10;
    out_is(8'h00);
    periph.system_clock_out <= 2'b11;
    periph.capture_unit2_pin <= 2'b11;
    wr(PA_ADDR_STEER1, 8'h03);
    out_is(8'h30);
    periph.comparator1_out <= 2'b11;
    out_is(8'h34);
    periph.sr_latch_out <= 2'b10;
    out_is(8'h30);
    rc("dir", PA_ADDR_DIR, 8'h08);
    periph <= '0;
    ext_val <= 6'h12;
    oth <= 3'b010;
    wr(PA_ADDR_DIR, 8'h3f);
    wr(PA_ADDR_STEER0, 8'h00);
    wait_n(6);
    chk("steered", {5'h00, steered}, 8'h03);
    wr(PA_ADDR_STEER0, 8'hac);
    wait_n(6);
    chk("steered", {5'h00, steered}, 8'h04);
    rc("dir", PA_ADDR_DIR, 8'h3f);
    report_and_stop;
  end
endmodule : pa_port_bench
`default_nettype wire
